// ===== core/spp_pkg.sv
// What this block does
// - Lock bits only set back by chip erase.
// - General write lock never gates store writes.
// - General read/write lock ignored by load/store.
// - App lock 10 blocks app writes only.
// - App lock 00 blocks writes, boot-side reads.
// - App lock 01 blocks boot-side reads only.
// - App modes 00/01 mask irqs in app when vectors are in boot.
// - Boot lock 10 blocks boot writes; 11 free.
// - Boot lock 00 blocks writes, app-side reads.
// - Boot lock 01 blocks app-side reads only.
// - Boot modes 00/01 mask irqs in boot when vectors are in app.
// - Fuse selects reset vector 0x0000 or boot.
// - Software has no path to fuses.
// - Ready irq while enabled, global, store idle.
// - Busy flag set on concurrent-section program.
// - Re-enable command clears busy flag.
// - Buffer load clears busy flag.
// - Re-enable needs store within four cycles.
// - Re-enable ignored while store enable set.
// - Re-enable during buffer load aborts load.
// - Store enable clears after store or timeout.
// - Stores act only from loader section.
package spp_pkg;

  localparam int ADDR_W = 13;

  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_LOCK = 4'h4;
  localparam logic [3:0] OFS_FUSE = 4'h8;

  localparam int CTRL_STORE_EN = 0;
  localparam int CTRL_REENABLE = 4;
  localparam int CTRL_BUSY     = 6;
  localparam int CTRL_IRQ_EN   = 7;

  localparam int LOCK_APP_LO  = 0;
  localparam int LOCK_APP_HI  = 1;
  localparam int LOCK_BOOT_LO = 2;
  localparam int LOCK_BOOT_HI = 3;

  localparam logic [3:0]  LOCK_ERASED    = 4'hf;
  localparam logic [2:0]  STORE_WINDOW   = 3'h4;
  localparam logic [12:0] HALTING_SECTION_START     = 13'h1000;
  localparam logic [12:0] APP_RESET_ADDR = 13'h0000;

  typedef enum logic [3:0] {
    SPP_CMD_BUF_LOAD = 4'b0000,
    SPP_CMD_ERASE    = 4'b0001,
    SPP_CMD_WRITE    = 4'b0010,
    SPP_CMD_LOCK_SET = 4'b0100,
    SPP_CMD_REENABLE = 4'b1000
  } spp_cmd_t;

  typedef struct packed {
    logic              valid;
    logic [ADDR_W-1:0] exec_addr;
    logic [ADDR_W-1:0] target_addr;
    logic [15:0]       data;
  } spp_acc_t;

  typedef struct packed {
    logic              start;
    logic              is_write;
    logic [ADDR_W-1:0] page_addr;
  } spp_op_t;

  typedef struct packed {
    logic              load;
    logic              abort;
    logic [ADDR_W-1:0] word_addr;
    logic [15:0]       data;
  } spp_buf_t;

endpackage

// ===== core/spp_lock_check.sv
`timescale 1ns/1ns
// Lock check for one flash section; the top uses one copy per section.
module spp_lock_check (
  // Two-bit lock field of this section
  input  wire logic [1:0] lock,
  // Section membership of the accesses
  input  wire logic       st_tgt_in,
  input  wire logic       ld_exec_in,
  input  wire logic       ld_tgt_in,
  input  wire logic       pc_in,
  input  wire logic       vec_in,
  // Verdicts
  output logic            wr_block,
  output logic            rd_block,
  output logic            irq_block
);

  // Lower bit programmed blocks writes: modes 10 and 00.
  assign wr_block  = st_tgt_in & ~lock[0];
  // Upper bit programmed blocks reads issued from the other section.
  assign rd_block  = ld_tgt_in & ~ld_exec_in & ~lock[1];
  // Running here with vectors in the other section would fetch locked code.
  assign irq_block = pc_in & ~vec_in & ~lock[1];

endmodule

// ===== core/spp_ctrl.sv
`timescale 1ns/1ns
module spp_ctrl (
  // Clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 rst,
  // Avalon-MM slave
  input  wire logic [3:0]           avs_address,
  input  wire logic                 avs_read,
  input  wire logic                 avs_write,
  input  wire logic [3:0]           avs_byteenable,
  input  wire logic [31:0]          avs_writedata,
  output logic [31:0]               avs_readdata,
  output logic                      avs_waitrequest,
  // CPU core side
  input  spp_pkg::spp_acc_t         store_acc,
  input  spp_pkg::spp_acc_t         load_acc,
  input  wire logic [12:0]          core_pc,
  input  wire logic                 global_irq_en,
  input  wire logic                 vec_in_boot,
  input  wire logic [12:0]          boot_start,
  // Non-volatile state and external programming
  input  wire logic [3:0]           lock_nv,
  input  wire logic                 boot_reset_fuse,
  input  wire logic                 chip_erase,
  input  wire logic                 prog_lock_wr,
  input  wire logic [3:0]           prog_lock_data,
  // Flash array side
  input  wire logic                 flash_op_done,
  output spp_pkg::spp_op_t          op_out,
  output spp_pkg::spp_buf_t         buf_out,
  // Verdicts and status
  output logic                      store_deny,
  output logic                      load_grant,
  output logic                      load_deny,
  output logic                      irq_suppress,
  output logic                      prog_ready_irq,
  output logic                      rw_section_busy,
  output logic [3:0]                lock_bits,
  output logic [12:0]               reset_vector
);

  logic                  wait_reg;
  logic [31:0]           rdata_reg;
  logic                  irq_en_reg;
  logic                  store_enable_reg;
  spp_pkg::spp_cmd_t     cmd_reg;
  logic [2:0]            win_reg;
  logic                  op_run_reg;
  logic                  op_wr_reg;
  logic                  busy_reg;
  logic                  buf_loaded_reg;
  logic                  loaded_reg;
  logic [3:0]            lock_reg;
  logic                  fuse_reg;
  logic [12:0]           rvec_reg;
  spp_pkg::spp_op_t      op_reg;
  spp_pkg::spp_buf_t     buf_reg;
  logic                  st_deny_reg;
  logic                  ld_grant_reg;
  logic                  ld_deny_reg;
  logic                  irq_sup_reg;
  logic                  rdy_irq_reg;

  // Bus decode: a request completes on the edge where waitrequest is low.
  wire        bus_req  = avs_read | avs_write;
  wire        bus_take = bus_req & ~wait_reg;
  wire        wait_next = ~(bus_req & wait_reg);
  wire        sel_ctrl = avs_address == spp_pkg::OFS_CTRL;
  wire        sel_lock = avs_address == spp_pkg::OFS_LOCK;
  wire        sel_fuse = avs_address == spp_pkg::OFS_FUSE;
  wire        wr_ctrl  = avs_write & bus_take & sel_ctrl & avs_byteenable[0];
  wire [3:0]  wr_cmd   = avs_writedata[4:1];
  wire        cmd_ok   = avs_writedata[spp_pkg::CTRL_STORE_EN] &
                         ((wr_cmd & (wr_cmd - 4'h1)) == 4'h0);
  // Only the documented command patterns arm, and never over a running store.
  wire        arm      = wr_ctrl & ~store_enable_reg & cmd_ok;
  wire        abort_now = arm & avs_writedata[spp_pkg::CTRL_REENABLE] &
                          buf_loaded_reg;

  wire [7:0]  ctrl_view = {irq_en_reg, busy_reg, 1'b0, cmd_reg, store_enable_reg};
  wire [31:0] rd_mux = sel_ctrl ? {24'h000000, ctrl_view} :
                       sel_lock ? {28'h0000000, lock_reg} :
                       sel_fuse ? {18'h00000, rvec_reg, fuse_reg} :
                       32'h00000000;

  // Section classification of every access, every cycle.
  wire st_exec_boot = store_acc.exec_addr >= boot_start;
  wire st_tgt_boot  = store_acc.target_addr >= boot_start;
  wire st_tgt_rww   = store_acc.target_addr < spp_pkg::HALTING_SECTION_START;
  wire ld_exec_boot = load_acc.exec_addr >= boot_start;
  wire ld_tgt_boot  = load_acc.target_addr >= boot_start;
  wire ld_tgt_rww   = load_acc.target_addr < spp_pkg::HALTING_SECTION_START;
  wire pc_boot      = core_pc >= boot_start;

  logic app_wr_blk;
  logic app_rd_blk;
  logic app_irq_blk;
  logic boot_wr_blk;
  logic boot_rd_blk;
  logic boot_irq_blk;

  spp_lock_check u_app_check (
    .lock       (lock_reg[spp_pkg::LOCK_APP_HI:spp_pkg::LOCK_APP_LO]),
    .st_tgt_in  (~st_tgt_boot),
    .ld_exec_in (~ld_exec_boot),
    .ld_tgt_in  (~ld_tgt_boot),
    .pc_in      (~pc_boot),
    .vec_in     (~vec_in_boot),
    .wr_block   (app_wr_blk),
    .rd_block   (app_rd_blk),
    .irq_block  (app_irq_blk)
  );

  spp_lock_check u_boot_check (
    .lock       (lock_reg[spp_pkg::LOCK_BOOT_HI:spp_pkg::LOCK_BOOT_LO]),
    .st_tgt_in  (st_tgt_boot),
    .ld_exec_in (ld_exec_boot),
    .ld_tgt_in  (ld_tgt_boot),
    .pc_in      (pc_boot),
    .vec_in     (vec_in_boot),
    .wr_block   (boot_wr_blk),
    .rd_block   (boot_rd_blk),
    .irq_block  (boot_irq_blk)
  );

  // Store decode. There is no general lock input at all, so of the lock bits only
  // the two section fields can stop a store or a load.
  wire store_go  = store_acc.valid & store_enable_reg & ~op_run_reg &
                   (win_reg != 3'h0);
  wire store_ok  = store_go & st_exec_boot;
  wire is_prog   = (cmd_reg == spp_pkg::SPP_CMD_ERASE) |
                   (cmd_reg == spp_pkg::SPP_CMD_WRITE);
  wire st_wr_blk = app_wr_blk | boot_wr_blk;
  wire prog_start = store_ok & is_prog & ~st_wr_blk;
  wire st_refuse = store_go & (~st_exec_boot | (is_prog & st_wr_blk));
  wire do_bufld  = store_ok & (cmd_reg == spp_pkg::SPP_CMD_BUF_LOAD);
  wire do_reen   = store_ok & (cmd_reg == spp_pkg::SPP_CMD_REENABLE);
  wire do_lkset  = store_ok & (cmd_reg == spp_pkg::SPP_CMD_LOCK_SET);
  wire op_end    = op_run_reg & flash_op_done;
  // Store enable drops after a plain store, after the window, or at op end.
  wire store_enable_clr = (store_go & ~prog_start) | op_end |
                   (~op_run_reg & ~store_go & (win_reg == 3'h1));

  wire [3:0] lk_sw  = do_lkset ? store_acc.data[3:0] : spp_pkg::LOCK_ERASED;
  wire [3:0] lk_ext = prog_lock_wr ? prog_lock_data : spp_pkg::LOCK_ERASED;
  // Programming only clears lock bits; nothing here can set one back.
  wire [3:0] lock_next = lock_reg & lk_sw & lk_ext;

  wire ld_refuse = app_rd_blk | boot_rd_blk | (busy_reg & ld_tgt_rww);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wait_reg  <= 1'b1;
      rdata_reg <= 32'h00000000;
    end else begin
      wait_reg <= wait_next;
      if (bus_req & wait_reg) begin
        rdata_reg <= rd_mux;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      irq_en_reg <= 1'b0;
    end else if (wr_ctrl) begin
      irq_en_reg <= avs_writedata[spp_pkg::CTRL_IRQ_EN];
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      store_enable_reg <= 1'b0;
      cmd_reg   <= spp_pkg::SPP_CMD_BUF_LOAD;
      win_reg   <= 3'h0;
    end else if (arm) begin
      store_enable_reg <= 1'b1;
      cmd_reg   <= spp_pkg::spp_cmd_t'(wr_cmd);
      win_reg   <= spp_pkg::STORE_WINDOW;
    end else begin
      win_reg <= (store_go || win_reg == 3'h0) ? 3'h0 : win_reg - 3'h1;
      if (store_enable_clr) begin
        store_enable_reg <= 1'b0;
        cmd_reg   <= spp_pkg::SPP_CMD_BUF_LOAD;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      op_run_reg <= 1'b0;
      op_wr_reg  <= 1'b0;
    end else if (prog_start) begin
      op_run_reg <= 1'b1;
      op_wr_reg  <= cmd_reg == spp_pkg::SPP_CMD_WRITE;
    end else if (op_end) begin
      op_run_reg <= 1'b0;
    end
  end

  // Setting wins over clearing for both flags.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      busy_reg       <= 1'b0;
      buf_loaded_reg <= 1'b0;
    end else begin
      if (prog_start & st_tgt_rww) begin
        busy_reg <= 1'b1;
      end else if (do_reen | do_bufld) begin
        busy_reg <= 1'b0;
      end
      if (do_bufld) begin
        buf_loaded_reg <= 1'b1;
      end else if (abort_now | (op_end & op_wr_reg)) begin
        buf_loaded_reg <= 1'b0;
      end
    end
  end

  // Non-volatile values are caught on the first edge after reset release.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      loaded_reg <= 1'b0;
      lock_reg   <= spp_pkg::LOCK_ERASED;
      fuse_reg   <= 1'b1;
    end else if (~loaded_reg) begin
      loaded_reg <= 1'b1;
      lock_reg   <= lock_nv;
      fuse_reg   <= boot_reset_fuse;
    end else if (chip_erase) begin
      lock_reg <= spp_pkg::LOCK_ERASED;
    end else begin
      lock_reg <= lock_next;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rvec_reg <= spp_pkg::APP_RESET_ADDR;
    end else begin
      rvec_reg <= fuse_reg ? spp_pkg::APP_RESET_ADDR : boot_start;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      op_reg  <= '0;
      buf_reg <= '0;
    end else begin
      op_reg.start     <= prog_start;
      op_reg.is_write  <= cmd_reg == spp_pkg::SPP_CMD_WRITE;
      op_reg.page_addr <= prog_start ? store_acc.target_addr : op_reg.page_addr;
      buf_reg.load     <= do_bufld;
      buf_reg.abort    <= abort_now;
      buf_reg.word_addr <= store_acc.target_addr;
      buf_reg.data     <= store_acc.data;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_deny_reg  <= 1'b0;
      ld_grant_reg <= 1'b0;
      ld_deny_reg  <= 1'b0;
      irq_sup_reg  <= 1'b0;
      rdy_irq_reg  <= 1'b0;
    end else begin
      st_deny_reg  <= st_refuse;
      ld_grant_reg <= load_acc.valid & ~ld_refuse;
      ld_deny_reg  <= load_acc.valid & ld_refuse;
      irq_sup_reg  <= app_irq_blk | boot_irq_blk;
      rdy_irq_reg  <= irq_en_reg & global_irq_en & ~store_enable_reg;
    end
  end

  assign avs_waitrequest = wait_reg;
  assign avs_readdata    = rdata_reg;
  assign op_out          = op_reg;
  assign buf_out         = buf_reg;
  assign store_deny      = st_deny_reg;
  assign load_grant      = ld_grant_reg;
  assign load_deny       = ld_deny_reg;
  assign irq_suppress    = irq_sup_reg;
  assign prog_ready_irq  = rdy_irq_reg;
  assign rw_section_busy = busy_reg;
  assign lock_bits       = lock_reg;
  assign reset_vector    = rvec_reg;

  ready_irq_a: assert property (
    @(posedge core_clk) disable iff (rst)
    (irq_en_reg && global_irq_en && !store_enable_reg) |=> prog_ready_irq)
    else $error("ready interrupt not requested");

  store_window_a: assert property (
    @(posedge core_clk) disable iff (rst)
    $rose(store_enable_reg) |-> ##[1:4] (!store_enable_reg || op_run_reg))
    else $error("store enable outlived its window");

  busy_set_a: assert property (
    @(posedge core_clk) disable iff (rst)
    (prog_start && st_tgt_rww) |=> busy_reg ##0 op_out.start)
    else $error("busy flag not set by program start");

  busy_read_a: assert property (
    @(posedge core_clk) disable iff (rst)
    (load_acc.valid && busy_reg && ld_tgt_rww) |=> (load_deny && !load_grant))
    else $error("load of busy section granted");

  app_write_a: assert property (
    @(posedge core_clk) disable iff (rst)
    (store_go && is_prog && !st_tgt_boot && !lock_reg[spp_pkg::LOCK_APP_LO])
      |=> (!op_out.start && store_deny))
    else $error("write to locked application section started");

  app_read_a: assert property (
    @(posedge core_clk) disable iff (rst)
    (load_acc.valid && ld_exec_boot && !ld_tgt_boot &&
     !lock_reg[spp_pkg::LOCK_APP_HI]) |=> load_deny)
    else $error("loader read of locked application allowed");

  boot_read_a: assert property (
    @(posedge core_clk) disable iff (rst)
    (load_acc.valid && !ld_exec_boot && ld_tgt_boot &&
     !lock_reg[spp_pkg::LOCK_BOOT_HI]) |=> load_deny)
    else $error("application read of locked loader allowed");

  app_store_a: assert property (
    @(posedge core_clk) disable iff (rst)
    (store_go && !st_exec_boot) |=> (!op_out.start && !buf_out.load && store_deny))
    else $error("store from application section took effect");

  reen_ignore_a: assert property (
    @(posedge core_clk) disable iff (rst)
    (wr_ctrl && store_enable_reg && !store_enable_clr) |=> $stable(cmd_reg))
    else $error("command accepted while store enable set");

  lock_rise_a: assert property (
    @(posedge core_clk) disable iff (rst)
    (loaded_reg && !chip_erase) |=> ((lock_reg & ~$past(lock_reg)) == 4'h0))
    else $error("lock bit returned without chip erase");

endmodule

// ===== test/spp_core_model.sv
`timescale 1ns/1ns
// Behavioural CPU core issuing store and load program-memory instructions.
module spp_core_model (
  // Clock
  input  wire logic          core_clk,
  // Verdicts from the block
  input  wire logic          load_grant,
  input  wire logic          load_deny,
  input  wire logic          store_deny,
  // Instruction requests
  output spp_pkg::spp_acc_t  store_acc,
  output spp_pkg::spp_acc_t  load_acc
);
  initial begin
    store_acc = '0;
    load_acc  = '0;
  end

  // A gap of three cycles lands on the last edge of the window; four misses it on purpose.
  task automatic store(input logic [12:0] ex, input logic [12:0] tg, input logic [15:0] d,
                       input int gap, output logic deny);
    repeat (gap) @(posedge core_clk);
    store_acc <= '{1'b1, ex, tg, d};
    @(posedge core_clk);
    // Released lines carry the inverse so a stale value is never read as live.
    store_acc <= '{1'b0, ~ex, ~tg, ~d};
    @(posedge core_clk);
    deny = store_deny;
  endtask

  task automatic load(input logic [12:0] ex, input logic [12:0] tg, output logic grant,
                      output logic deny);
    load_acc <= '{1'b1, ex, tg, 16'h0000};
    @(posedge core_clk);
    load_acc <= '{1'b0, ~ex, ~tg, 16'hffff};
    @(posedge core_clk);
    grant = load_grant;
    deny  = load_deny;
  endtask
endmodule

// ===== test/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  localparam logic [12:0] BOOT = 13'h1800;
  logic              core_clk, rst, avs_read, avs_write, avs_waitrequest;
  logic [3:0]        avs_address, lock_nv, prog_lock_data, lock_bits;
  logic [31:0]       avs_writedata, avs_readdata, q;
  spp_pkg::spp_acc_t store_acc, load_acc;
  spp_pkg::spp_op_t  op_out;
  spp_pkg::spp_buf_t buf_out;
  logic [12:0]       core_pc, reset_vector, ex, tg, rv;
  logic              global_irq_en, vec_in_boot, boot_reset_fuse, store_deny, load_grant;
  logic              load_deny, irq_suppress, prog_ready_irq, rw_section_busy, dn, gr, x;
  logic              chip_erase, prog_lock_wr, flash_op_done;
  logic [2:0]        pls;
  logic [15:0]       lfsr = 16'h11ad;
  int                fail_count, comparisons, aborts;

  assign {chip_erase, prog_lock_wr, flash_op_done} = pls;

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  always @(posedge core_clk) if (buf_out.abort === 1'b1) aborts++;

  spp_ctrl dut (
    .core_clk(core_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_byteenable(4'hf), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .store_acc(store_acc), .load_acc(load_acc), .core_pc(core_pc),
    .global_irq_en(global_irq_en), .vec_in_boot(vec_in_boot), .boot_start(BOOT),
    .lock_nv(lock_nv), .boot_reset_fuse(boot_reset_fuse), .chip_erase(chip_erase),
    .prog_lock_wr(prog_lock_wr), .prog_lock_data(prog_lock_data),
    .flash_op_done(flash_op_done), .op_out(op_out), .buf_out(buf_out),
    .store_deny(store_deny), .load_grant(load_grant), .load_deny(load_deny),
    .irq_suppress(irq_suppress), .prog_ready_irq(prog_ready_irq),
    .rw_section_busy(rw_section_busy), .lock_bits(lock_bits), .reset_vector(reset_vector)
  );

  spp_core_model cpu (
    .core_clk(core_clk), .load_grant(load_grant), .load_deny(load_deny),
    .store_deny(store_deny), .store_acc(store_acc), .load_acc(load_acc)
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // The request stands until waitrequest is seen low; only then is it dropped.
  // A wait that never sees waitrequest low is ended by the watchdog alone.
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= ~wr;
    do begin
      @(posedge core_clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask

  task automatic rst_cycle;
    rst <= 1'b1;
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask

  task automatic pulse(input logic [2:0] p);
    pls <= p;
    @(posedge core_clk);
    pls <= 3'h0;
    repeat (2) @(posedge core_clk);
  endtask

  function automatic logic [12:0] addr(input logic boot);
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return {boot, boot, lfsr[10:0]};
  endfunction

  // Loads cross sections only as the opposite section's lock allows.
  function automatic logic exp_ld(input logic [3:0] lk, input logic [12:0] e,
                                  input logic [12:0] t, input logic busy);
    return (busy && t < spp_pkg::HALTING_SECTION_START) || (e >= BOOT && t < BOOT && !lk[1]) ||
           (e < BOOT && t >= BOOT && !lk[3]);
  endfunction

  initial begin
    repeat (20000) @(posedge core_clk);
    fail_count++;
    wrap_up();
  end

  initial begin
    rst = 1'b1;
    {avs_read, avs_write, global_irq_en, vec_in_boot} = 4'h0;
    {avs_address, avs_writedata, core_pc, pls} = '0;
    {lock_nv, prog_lock_data, boot_reset_fuse} = 9'h1ff;
    for (int f = 0; f < 2; f++) begin
      boot_reset_fuse <= f[0];
      rst_cycle();
      rv = f[0] ? spp_pkg::APP_RESET_ADDR : BOOT;
      chk(32'(reset_vector), 32'(rv));
      bus(1'b0, spp_pkg::OFS_FUSE, 32'h0);
      chk(q, {18'h0, rv, f[0]});
      bus(1'b1, spp_pkg::OFS_FUSE, ~q);
      bus(1'b0, spp_pkg::OFS_FUSE, 32'h0);
      chk(q, {18'h0, rv, f[0]});
      bus(1'b0, spp_pkg::OFS_CTRL, 32'h0);
      chk(q, 32'h0);
      bus(1'b0, 4'hc, 32'h0);
      chk(q, 32'h0);
    end
    for (int m = 0; m < 16; m++) begin
      for (int k = 0; k < 4; k++) begin
        lock_nv <= m[3:0];
        vec_in_boot <= k[1];
        ex = addr(k[0]);
        tg = addr(k[1]);
        core_pc <= ex;
        rst_cycle();
        chk(32'(lock_bits), 32'(m));
        x = k[1] ? (!k[0] && !m[1]) : (k[0] && !m[3]);
        chk(32'(irq_suppress), 32'(x));
        cpu.load(ex, tg, gr, dn);
        x = exp_ld(m[3:0], ex, tg, 1'b0);
        chk(32'({gr, dn}), 32'({~x, x}));
        bus(1'b1, spp_pkg::OFS_CTRL, 32'h03);
        cpu.store(ex, tg, lfsr, 0, dn);
        x = !k[0] || (k[1] ? !m[2] : !m[0]);
        chk(32'({dn, op_out.start}), 32'({x, ~x}));
      end
    end
    lock_nv <= 4'hf;
    rst_cycle();
    bus(1'b1, spp_pkg::OFS_CTRL, 32'h09);
    cpu.store(BOOT, BOOT, 16'h000a, 0, dn);
    repeat (2) @(posedge core_clk);
    chk(32'(lock_bits), 32'h0a);
    prog_lock_data <= 4'h7;
    pulse(3'b010);
    chk(32'(lock_bits), 32'h02);
    bus(1'b1, spp_pkg::OFS_CTRL, 32'h09);
    cpu.store(BOOT, BOOT, 16'h000f, 0, dn);
    repeat (2) @(posedge core_clk);
    chk(32'(lock_bits), 32'h02);
    pulse(3'b100);
    chk(32'(lock_bits), 32'h0f);
    bus(1'b1, spp_pkg::OFS_CTRL, 32'h03);
    cpu.store(BOOT, 13'h0100, lfsr, 3, dn);
    chk(32'({dn, op_out.start, rw_section_busy}), 32'h3);
    cpu.load(BOOT, addr(1'b0), gr, dn);
    chk(32'({gr, dn}), 32'h1);
    bus(1'b1, spp_pkg::OFS_CTRL, 32'h11);
    bus(1'b0, spp_pkg::OFS_CTRL, 32'h0);
    chk(q, 32'h43);
    pulse(3'b001);
    bus(1'b0, spp_pkg::OFS_CTRL, 32'h0);
    chk(q, 32'h40);
    bus(1'b1, spp_pkg::OFS_CTRL, 32'h11);
    cpu.store(BOOT, 13'h0100, lfsr, 0, dn);
    chk(32'(rw_section_busy), 32'h0);
    bus(1'b1, spp_pkg::OFS_CTRL, 32'h05);
    cpu.store(BOOT, 13'h0100, lfsr, 0, dn);
    chk(32'(rw_section_busy), 32'h1);
    chk(32'({op_out.is_write, op_out.page_addr}), 32'h2100);
    pulse(3'b001);
    bus(1'b1, spp_pkg::OFS_CTRL, 32'h01);
    tg = addr(1'b0);
    cpu.store(BOOT, tg, lfsr, 0, dn);
    chk(32'({buf_out.load, rw_section_busy}), 32'h2);
    chk({3'h0, buf_out.word_addr, buf_out.data}, {3'h0, tg, lfsr});
    bus(1'b1, spp_pkg::OFS_CTRL, 32'h11);
    cpu.store(BOOT, BOOT, lfsr, 0, dn);
    repeat (2) @(posedge core_clk);
    chk(32'(aborts), 32'h1);
    global_irq_en <= 1'b1;
    bus(1'b1, spp_pkg::OFS_CTRL, 32'h80);
    repeat (2) @(posedge core_clk);
    chk(32'(prog_ready_irq), 32'h1);
    bus(1'b1, spp_pkg::OFS_CTRL, 32'h81);
    repeat (2) @(posedge core_clk);
    chk(32'(prog_ready_irq), 32'h0);
    repeat (4) @(posedge core_clk);
    chk(32'(prog_ready_irq), 32'h1);
    bus(1'b1, spp_pkg::OFS_CTRL, 32'h81);
    tg = addr(1'b0);
    cpu.store(BOOT, tg, lfsr, 4, dn);
    chk(32'({dn, buf_out.load}), 32'h0);
    global_irq_en <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk(32'(prog_ready_irq), 32'h0);
    wrap_up();
  end
endmodule
